// File: rtl/smd_pkg.sv
/*
  Package for the supply margin DAC controller: command codes, field
  encodings, timing figures, channel state and the command port carriers.
  Assumes a single 100 MHz core clock shared by every user of the package.
*/
package smd_pkg;

  // ----------------------------------------------------------------
  // sizes and command codes
  // ----------------------------------------------------------------
  localparam int unsigned NCH        = 16;
  localparam logic [7:0] CMD_OPER    = 8'h01;
  localparam logic [7:0] CMD_FLT_CLR = 8'h03;
  localparam logic [7:0] CMD_TGT_HI  = 8'h25;
  localparam logic [7:0] CMD_TGT_LO  = 8'h26;
  localparam logic [7:0] CMD_STATUS  = 8'h80;
  localparam logic [7:0] CMD_MODE    = 8'hD1;
  localparam logic [7:0] CMD_MARGIN  = 8'hDF;
  localparam logic [7:0] CMD_DAC_LVL = 8'hE0;
  localparam logic [7:0] CMD_PIN_CFG = 8'hE9;

  // ----------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_DAC  = 3'h0;
  localparam logic [2:0] SEL_ON   = 3'h1;
  localparam logic [2:0] SEL_OFF  = 3'h2;
  localparam logic [2:0] SEL_GOOD = 3'h3;
  localparam logic [2:0] SEL_ALRM = 3'h4;
  localparam logic [1:0] OP_NONE  = 2'h0;
  localparam logic [1:0] OP_LOW   = 2'h1;
  localparam logic [1:0] OP_HIGH  = 2'h2;
  localparam logic [7:0] DAC_ZERO = 8'h00;
  localparam logic [7:0] DAC_FULL = 8'hFF;

  // ----------------------------------------------------------------
  // timing, in milliseconds unless named otherwise
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned MS_CYCLES_DEF = 1000 * CLK_MHZ;
  localparam logic [2:0]  SAMPLE_MS     = 3'h5;
  localparam logic [1:0]  LAST_SAMPLE   = 2'h3;
  localparam logic [6:0]  HOLD_MS       = 7'd100;
  localparam logic [12:0] OVERHEAD_MS   = 13'd2;
  localparam logic [22:0] PCT_SCALE     = 23'd100;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [3:0]  page;
    logic [7:0]  code;
    logic [31:0] data;
  } smd_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } smd_rsp_t;

  typedef struct packed {
    logic        slope;
    logic        open_loop;
    logic [7:0]  fixed_level_value;
    logic [15:0] good_input_channel_mask;
    logic [3:0]  off_dly;
    logic [3:0]  on_dly;
    logic        output_drive_type;
    logic        output_polarity;
    logic [2:0]  sel;
    logic [1:0]  op;
    logic        ign;
    logic [15:0] tgt_hi;
    logic [15:0] tgt_lo;
    logic [7:0]  dac;
    logic        active;
    logic        trim_en;
    logic [17:0] acc;
    logic        first;
    logic        chk;
    logic        dir;
    logic        fault;
    logic [12:0] dcnt;
    logic        pend;
    logic        asserted;
    logic        pin_lvl;
    logic        pin_oe;
    logic [6:0]  hold_ms;
  } smd_ch_t;

  // delay code to milliseconds
  function automatic logic [12:0] smd_delay_ms(input logic [3:0] code);
    unique case (code)
      4'h0: smd_delay_ms = 13'd0;
      4'h1: smd_delay_ms = 13'd5;
      4'h2: smd_delay_ms = 13'd10;
      4'h3: smd_delay_ms = 13'd20;
      4'h4: smd_delay_ms = 13'd40;
      4'h5: smd_delay_ms = 13'd60;
      4'h6: smd_delay_ms = 13'd80;
      4'h7: smd_delay_ms = 13'd100;
      4'h8: smd_delay_ms = 13'd200;
      4'h9: smd_delay_ms = 13'd400;
      4'hA: smd_delay_ms = 13'd600;
      4'hB: smd_delay_ms = 13'd800;
      4'hC: smd_delay_ms = 13'd1000;
      4'hD: smd_delay_ms = 13'd1500;
      4'hE: smd_delay_ms = 13'd2000;
      default: smd_delay_ms = 13'd4000;
    endcase
  endfunction

endpackage

// File: rtl/smd_margin_ctrl.sv
/*
  Sixteen-channel margin DAC and general output controller.
  Assumes registered ADC averages on vout_i in core_clk_i's domain, alarms
  and power-good summary from same-clock logic, general inputs from pins.

*/
`timescale 1ns/1ps
module smd_margin_ctrl #(
  parameter int unsigned MS_CYCLES = smd_pkg::MS_CYCLES_DEF
) (
  // clock and reset
  input  wire logic                    core_clk_i,
  input  wire logic                    reset_i,
  // management command port
  input  wire smd_pkg::smd_cmd_t       cmd_i,
  output smd_pkg::smd_rsp_t            rsp_o,
  // supply monitor side
  input  wire logic [15:0][15:0]       vout_i,
  input  wire logic                    all_good_i,
  input  wire logic [15:0]             setpoint_active_i,
  input  wire logic [15:0]             alarm_i,
  input  wire logic [15:0]             general_input_i,
  // trim outputs
  output logic      [15:0][7:0]        trim_output_pin_level_o,
  output logic      [15:0]             trim_output_pin_en_o,
  // general output pins
  output logic      [15:0]             general_output_o,
  output logic      [15:0]             general_output_oe_o,
  // status
  output logic                         status_margin_o,
  output logic                         alert_o,
  output logic                         fault_hold_o
);
  import smd_pkg::*;

  if (MS_CYCLES < 2 || MS_CYCLES >= (1 << 20)) begin : g_ms_check
    $error("MS_CYCLES out of range");
  end

  localparam logic [19:0] MS_LAST = 20'(MS_CYCLES - 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    smd_ch_t [15:0] ch;
    logic [19:0]    ms_cnt;
    logic [2:0]     smp_ms;
    logic [1:0]     smp_n;
    logic           alert_en;
    logic [15:0]    gin_s1;
    logic [15:0]    gin_s2;
    logic           stat;
    logic           alert;
    logic           hold;
    smd_rsp_t       rsp;
  } smd_state_t;

  smd_state_t s_q;
  smd_state_t s_d;

  function automatic logic off_target(input logic [15:0] avg, input logic [15:0] tgt);
    logic [15:0] err;
    err = (avg > tgt) ? avg - tgt : tgt - avg;
    off_target = ({7'h0, err} * PCT_SCALE) > {7'h0, tgt};
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        ms_tick;
    logic        smp_tick;
    logic        eval;
    logic        wr;
    logic        want;
    logic        raise;
    logic        inc;
    logic        cond;
    logic        timed;
    logic        is_wr;
    logic        reload;
    logic        fset;
    logic        off_req;
    logic [15:0] avg;
    logic [15:0] tgt;
    logic [17:0] sum;
    logic [12:0] lim;
    ms_tick  = s_q.ms_cnt == MS_LAST;
    smp_tick = ms_tick && (s_q.smp_ms == SAMPLE_MS - 3'h1);
    eval     = smp_tick && (s_q.smp_n == LAST_SAMPLE);
    wr       = cmd_i.valid && cmd_i.write;
    want = 1'b0; raise = 1'b0; inc = 1'b0; cond = 1'b0; timed = 1'b0;
    is_wr = 1'b0; reload = 1'b0; fset = 1'b0; off_req = 1'b0;
    avg = 16'h0000; tgt = 16'h0000; sum = 18'h00000; lim = 13'h0000;
    s_d = s_q;
    s_d.gin_s1 = general_input_i;
    s_d.gin_s2 = s_q.gin_s1;
    s_d.ms_cnt = ms_tick ? 20'h00000 : s_q.ms_cnt + 20'h00001;
    if (ms_tick) begin
      s_d.smp_ms = smp_tick ? 3'h0 : s_q.smp_ms + 3'h1;
    end
    if (smp_tick) begin
      s_d.smp_n = s_q.smp_n + 2'h1;
    end
    if (wr && cmd_i.code == CMD_MODE) begin
      s_d.alert_en = cmd_i.data[0];
    end
    for (int i = 0; i < NCH; i++) begin
      is_wr  = wr && (cmd_i.page == 4'(i));
      reload = 1'b0;
      fset   = 1'b0;
      // the off write also clears the ignore bit, so judge it before it lands
      off_req = is_wr && (cmd_i.code == CMD_OPER) && (cmd_i.data[1:0] == OP_NONE) &&
                s_q.ch[i].active && s_q.ch[i].ign;
      if (is_wr && cmd_i.code == CMD_MARGIN) begin
        s_d.ch[i].slope             = cmd_i.data[15];
        s_d.ch[i].open_loop         = cmd_i.data[14];
        s_d.ch[i].fixed_level_value = cmd_i.data[7:0];
      end
      if (is_wr && cmd_i.code == CMD_PIN_CFG) begin
        s_d.ch[i].good_input_channel_mask = cmd_i.data[31:16];
        s_d.ch[i].off_dly           = cmd_i.data[15:12];
        s_d.ch[i].on_dly            = cmd_i.data[11:8];
        s_d.ch[i].output_drive_type = cmd_i.data[7];
        s_d.ch[i].output_polarity   = cmd_i.data[6];
        s_d.ch[i].sel               = cmd_i.data[2:0];
        reload = 1'b1;
      end
      if (is_wr && cmd_i.code == CMD_OPER) begin
        s_d.ch[i].op  = cmd_i.data[1:0];
        s_d.ch[i].ign = cmd_i.data[2];
      end
      if (is_wr && cmd_i.code == CMD_TGT_HI) begin
        s_d.ch[i].tgt_hi = cmd_i.data[15:0];
      end
      if (is_wr && cmd_i.code == CMD_TGT_LO) begin
        s_d.ch[i].tgt_lo = cmd_i.data[15:0];
      end

      // margining: a non-DAC function wins over any margin request
      want = (s_q.ch[i].op != OP_NONE) && (s_q.ch[i].sel == SEL_DAC);
      sum  = s_q.ch[i].acc + {2'h0, vout_i[i]};
      avg  = sum[17:2];
      tgt  = (s_q.ch[i].op == OP_HIGH) ? s_q.ch[i].tgt_hi : s_q.ch[i].tgt_lo;
      if (!s_q.ch[i].active) begin
        // closed loop starts on a sample-cycle boundary so the first average is whole
        if (want && all_good_i && (s_q.ch[i].open_loop || eval)) begin
          s_d.ch[i].active = 1'b1;
          s_d.ch[i].dac    = s_q.ch[i].fixed_level_value;
          s_d.ch[i].first  = 1'b1;
          s_d.ch[i].chk    = 1'b0;
          s_d.ch[i].acc    = 18'h00000;
        end
      end else if (!want) begin
        s_d.ch[i].active = 1'b0;
        if (s_q.ch[i].ign) begin
          s_d.ch[i].hold_ms = HOLD_MS;
        end
      end else if (s_q.ch[i].open_loop) begin
        s_d.ch[i].dac = s_q.ch[i].fixed_level_value;
      end else if (smp_tick) begin
        s_d.ch[i].acc = eval ? 18'h00000 : sum;
        if (eval && off_target(avg, tgt)) begin
          raise = avg < tgt;
          inc   = raise == s_q.ch[i].slope;
          if (s_q.ch[i].chk && raise != s_q.ch[i].dir) begin
            fset = 1'b1;
          end
          s_d.ch[i].chk   = s_q.ch[i].first;
          s_d.ch[i].dir   = raise;
          s_d.ch[i].first = 1'b0;
          if (inc ? s_q.ch[i].dac == DAC_FULL : s_q.ch[i].dac == DAC_ZERO) begin
            fset = 1'b1;
          end else begin
            s_d.ch[i].dac = inc ? s_q.ch[i].dac + 8'h01 : s_q.ch[i].dac - 8'h01;
          end
        end else if (eval) begin
          s_d.ch[i].chk = 1'b0;
        end
      end
      if (ms_tick && s_q.ch[i].hold_ms != 7'h00) begin
        s_d.ch[i].hold_ms = s_q.ch[i].hold_ms - 7'h01;
      end
      if (off_req) begin
        s_d.ch[i].hold_ms = HOLD_MS;
      end
      // set wins over a clear in the same cycle; margining carries on
      if (wr && cmd_i.code == CMD_FLT_CLR && cmd_i.data[i]) begin
        s_d.ch[i].fault = 1'b0;
      end
      if (fset) begin
        s_d.ch[i].fault = 1'b1;
      end
      s_d.ch[i].trim_en = (s_q.ch[i].sel == SEL_DAC) &&
                          (s_q.ch[i].active || setpoint_active_i[i]);

      // general output function
      unique case (s_q.ch[i].sel)
        SEL_ON:   cond = 1'b1;
        SEL_GOOD: cond = &(~s_q.ch[i].good_input_channel_mask | s_q.gin_s2);
        SEL_ALRM: cond = |(s_q.ch[i].good_input_channel_mask & alarm_i);
        default:  cond = 1'b0;
      endcase
      timed = (s_q.ch[i].sel == SEL_GOOD) || (s_q.ch[i].sel == SEL_ALRM);
      lim   = smd_delay_ms(cond ? s_q.ch[i].on_dly : s_q.ch[i].off_dly) + OVERHEAD_MS;
      if (!timed) begin
        s_d.ch[i].asserted = cond;
        s_d.ch[i].pend     = cond;
        s_d.ch[i].dcnt     = 13'h0000;
      end else if (reload || cond != s_q.ch[i].pend || cond == s_q.ch[i].asserted) begin
        s_d.ch[i].pend = cond;
        s_d.ch[i].dcnt = 13'h0000;
      end else if (s_q.ch[i].dcnt > lim) begin
        // one tick past the limit: a partial first tick cannot cut the overhead below 2 ms
        s_d.ch[i].asserted = cond;
        s_d.ch[i].dcnt     = 13'h0000;
      end else if (ms_tick) begin
        s_d.ch[i].dcnt = s_q.ch[i].dcnt + 13'h0001;
      end
      if (s_q.ch[i].sel == SEL_DAC || s_q.ch[i].sel > SEL_ALRM) begin
        s_d.ch[i].pin_lvl = 1'b0;
        s_d.ch[i].pin_oe  = 1'b0;
      end else begin
        s_d.ch[i].pin_lvl = s_q.ch[i].asserted ~^ s_q.ch[i].output_polarity;
        s_d.ch[i].pin_oe  = !s_q.ch[i].output_drive_type ||
                            !(s_q.ch[i].asserted ~^ s_q.ch[i].output_polarity);
      end
    end

    s_d.stat = 1'b0;
    s_d.hold = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      s_d.stat = s_d.stat | s_d.ch[i].fault;
      s_d.hold = s_d.hold | (s_d.ch[i].hold_ms != 7'h00);
    end
    s_d.alert = s_d.stat && s_d.alert_en;

    // read answers, one cycle after the request
    s_d.rsp.valid = cmd_i.valid && !cmd_i.write;
    s_d.rsp.data  = 32'h00000000;
    if (cmd_i.valid && !cmd_i.write) begin
      unique case (cmd_i.code)
        CMD_MARGIN:  s_d.rsp.data = {16'h0000, s_q.ch[cmd_i.page].slope, s_q.ch[cmd_i.page].open_loop,
                                     6'h00, s_q.ch[cmd_i.page].fixed_level_value};
        CMD_PIN_CFG: s_d.rsp.data = {s_q.ch[cmd_i.page].good_input_channel_mask,
                                     s_q.ch[cmd_i.page].off_dly, s_q.ch[cmd_i.page].on_dly,
                                     s_q.ch[cmd_i.page].output_drive_type,
                                     s_q.ch[cmd_i.page].output_polarity, 3'h0,
                                     s_q.ch[cmd_i.page].sel};
        CMD_OPER:    s_d.rsp.data = {29'h0, s_q.ch[cmd_i.page].ign, s_q.ch[cmd_i.page].op};
        CMD_TGT_HI:  s_d.rsp.data = {16'h0000, s_q.ch[cmd_i.page].tgt_hi};
        CMD_TGT_LO:  s_d.rsp.data = {16'h0000, s_q.ch[cmd_i.page].tgt_lo};
        CMD_DAC_LVL: s_d.rsp.data = {23'h0, s_q.ch[cmd_i.page].active, s_q.ch[cmd_i.page].dac};
        CMD_MODE:    s_d.rsp.data = {31'h0, s_q.alert_en};
        CMD_STATUS: begin
          for (int i = 0; i < NCH; i++) begin
            s_d.rsp.data[i] = s_q.ch[i].fault;
          end
        end
        default:     s_d.rsp.data = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // no documented reset values: everything clears, pins float
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      trim_output_pin_level_o[i] = s_q.ch[i].dac;
      trim_output_pin_en_o[i]    = s_q.ch[i].trim_en;
      general_output_o[i]        = s_q.ch[i].pin_lvl;
      general_output_oe_o[i]     = s_q.ch[i].pin_oe;
    end
  end

  assign rsp_o           = s_q.rsp;
  assign status_margin_o = s_q.stat;
  assign alert_o         = s_q.alert;
  assign fault_hold_o    = s_q.hold;

endmodule

// File: bench/smd_margin_ctrl_assertions.sv
/*
  port checker for smd_margin_ctrl.
  assumes the bench binds it and keeps forced-pin writes on page 0.
*/
`timescale 1ns/1ps
module smd_margin_ctrl_checker #(
  parameter int unsigned MS_CYCLES = 20
) (
  // clock and reset
  input wire logic                core_clk_i,
  input wire logic                reset_i,
  // command port
  input wire smd_pkg::smd_cmd_t   cmd_i,
  input wire smd_pkg::smd_rsp_t   rsp_o,
  // supply side and pins
  input wire logic                all_good_i,
  input wire logic [15:0][7:0]    trim_output_pin_level_o,
  input wire logic [15:0]         trim_output_pin_en_o,
  input wire logic [15:0]         general_output_o,
  input wire logic [15:0]         general_output_oe_o,
  // status
  input wire logic                status_margin_o,
  input wire logic                alert_o,
  input wire logic                fault_hold_o
);
  import smd_pkg::*;
  // ------
  // helpers
  // ------
  logic [31:0] hold_q;
  logic        pin_wr;
  assign pin_wr = cmd_i.valid && cmd_i.write && cmd_i.code == CMD_PIN_CFG && cmd_i.page == 4'h0;
  // counts the suspension so both ends of it can be bounded
  always_ff @(posedge core_clk_i) begin
    if (reset_i || !fault_hold_o) begin
      hold_q <= 32'h0;
    end else begin
      hold_q <= hold_q + 32'h1;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // ------
  // properties
  // ------
  rsp_valid_a: assert property (cmd_i.valid && !cmd_i.write |=> rsp_o.valid)
    else $error("read left unanswered");
  rsp_cause_a: assert property (rsp_o.valid |-> $past(cmd_i.valid && !cmd_i.write))
    else $error("answer without read");
  margin_rsv_a: assert property (rsp_o.valid && $past(cmd_i.code) == CMD_MARGIN
    |-> rsp_o.data[31:16] == 16'h0 && rsp_o.data[13:8] == 6'h0) else $error("margin reserved bits set");
  pin_rsv_a: assert property (rsp_o.valid && $past(cmd_i.code) == CMD_PIN_CFG
    |-> rsp_o.data[5:3] == 3'h0) else $error("pin reserved bits set");
  force_on_a: assert property (pin_wr && cmd_i.data[7:0] == 8'h41
    |-> ##[1:3] general_output_o[0] && general_output_oe_o[0]) else $error("forced on missing");
  force_off_a: assert property (pin_wr && cmd_i.data[7:0] == 8'h42
    |-> ##[1:3] !general_output_o[0] && general_output_oe_o[0]) else $error("forced off missing");
  override_a: assert property (pin_wr && cmd_i.data[2:0] != SEL_DAC
    |-> ##[1:4] !trim_output_pin_en_o[0]) else $error("margining not overridden");
  start_good_a: assert property ($rose(trim_output_pin_en_o[0]) |-> $past(all_good_i, 2))
    else $error("trim driven before supplies good");
  step_size_a: assert property (trim_output_pin_en_o[0] && $past(trim_output_pin_en_o[0])
    && $changed(trim_output_pin_level_o[0])
    |-> 8'(trim_output_pin_level_o[0] - $past(trim_output_pin_level_o[0])) inside {8'h01, 8'hFF})
    else $error("trim moved more than one step");
  hold_min_a: assert property ($fell(fault_hold_o) |-> $past(hold_q) >= 98 * MS_CYCLES)
    else $error("suspension too short");
  hold_max_a: assert property (hold_q <= 102 * MS_CYCLES)
    else $error("suspension too long");
  alert_src_a: assert property (alert_o |-> status_margin_o || $past(status_margin_o))
    else $error("alert without margin fault");
  cover property ($rose(status_margin_o));
  cover property ($fell(fault_hold_o));
  cover property ($rose(trim_output_pin_en_o[0]));
endmodule

// File: bench/smd_supply_model.sv
/*
  supply feedback node model: reading follows the trim pin through a resistor.
  assumes positive-slope wiring and one clock of settling.
*/
`timescale 1ns/1ps
module smd_supply_model (
  // clock
  input  wire logic              core_clk_i,
  // trim pins
  input  wire logic [15:0][7:0]  level_i,
  input  wire logic [15:0]       en_i,
  // averaged readings
  output logic      [15:0][15:0] vout_o
);
  initial vout_o = '0;
  // a floating pin leaves the supply at its own nominal point
  always @(posedge core_clk_i) begin
    for (int c = 0; c < 16; c++) begin
      vout_o[c] <= en_i[c] ? {1'b0, level_i[c], 7'h00} : 16'h0800;
    end
  end
endmodule

// File: bench/testbench.sv
/*
  bench for smd_margin_ctrl: command tasks, pin and margining sequences.
  assumes MS_CYCLES of 20, so one millisecond is 20 clocks.
*/
`timescale 1ns/1ps
module testbench;
  import smd_pkg::*;
  localparam int unsigned MS = 20;
  logic              core_clk_i = 1'b0;
  logic              reset_i = 1'b1;
  smd_cmd_t          cmd_i = '0;
  smd_rsp_t          rsp_o;
  logic [15:0][15:0] vout_i;
  logic              all_good_i = 1'b0;
  logic [15:0]       setpoint_active_i = '0, alarm_i = '0, general_input_i = '0;
  logic [15:0][7:0]  trim_output_pin_level_o;
  logic [15:0]       trim_output_pin_en_o, general_output_o, general_output_oe_o;
  logic              status_margin_o, alert_o, fault_hold_o;
  logic [31:0]       rd_q;
  int                fails = 0, compares = 0, i;
  logic [7:0]        frc [5] = '{8'h41, 8'h01, 8'h42, 8'h81, 8'hC1};
  logic [1:0]        fexp [5] = '{2'h3, 2'h1, 2'h1, 2'h1, 2'h2};
  always #5 core_clk_i = ~core_clk_i;
  smd_margin_ctrl #(.MS_CYCLES(MS)) u_smd_margin_ctrl (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .cmd_i(cmd_i), .rsp_o(rsp_o), .vout_i(vout_i), .all_good_i(all_good_i),
    .setpoint_active_i(setpoint_active_i), .alarm_i(alarm_i), .general_input_i(general_input_i),
    .trim_output_pin_level_o(trim_output_pin_level_o), .trim_output_pin_en_o(trim_output_pin_en_o),
    .general_output_o(general_output_o), .general_output_oe_o(general_output_oe_o),
    .status_margin_o(status_margin_o), .alert_o(alert_o), .fault_hold_o(fault_hold_o));
  smd_supply_model u_smd_supply_model (.core_clk_i(core_clk_i), .level_i(trim_output_pin_level_o),
    .en_i(trim_output_pin_en_o), .vout_o(vout_i));
  // ------
  // tasks
  // ------
  task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic chk1(input string n, input logic got, input logic exp);
    check(n, {31'h0, got}, {31'h0, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic wr(input logic [3:0] pg, input logic [7:0] code, input logic [31:0] d);
    @(negedge core_clk_i);
    cmd_i = '{1'b1, 1'b1, pg, code, d};
    @(negedge core_clk_i);
    cmd_i.valid = 1'b0;
  endtask
  // the answer stands for one cycle, so it is taken at the next falling edge
  task automatic rd(input logic [3:0] pg, input logic [7:0] code);
    @(negedge core_clk_i);
    cmd_i = '{1'b1, 1'b0, pg, code, 32'h0};
    @(negedge core_clk_i);
    cmd_i.valid = 1'b0;
    chk1("answer", rsp_o.valid, 1'b1);
    rd_q = rsp_o.data;
  endtask
  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #200_000;
    fails++;
    complete_run();
  end
  // ------
  // sequence
  // ------
  initial begin
    cyc(2);
    reset_i = 1'b0;
    cyc(1);
    check("idle pins", {general_output_oe_o, trim_output_pin_en_o}, 32'h0);
    wr(4'h0, CMD_MARGIN, 32'hFFFF_FFFF);
    rd(4'h0, CMD_MARGIN);
    check("margin cfg", rd_q, 32'h0000_C0FF);
    wr(4'h0, CMD_PIN_CFG, 32'hFFFF_FFFF);
    rd(4'h0, CMD_PIN_CFG);
    check("pin cfg", rd_q, 32'hFFFF_FFC7);
    chk1("reserved select", general_output_oe_o[0], 1'b0);
    rd(4'h0, 8'h55);
    check("unmapped", rd_q, 32'h0);
    for (i = 0; i < 5; i++) begin
      wr(4'h0, CMD_PIN_CFG, {24'h00FF, frc[i]});
      cyc(4);
      check("forced pin", 32'({general_output_o[0], general_output_oe_o[0]}), 32'(fexp[i]));
    end
    wr(4'h1, CMD_PIN_CFG, 32'h0006_1143);
    general_input_i[1] = 1'b1;
    cyc(10 * MS);
    chk1("good partial", general_output_o[1], 1'b0);
    general_input_i[2] = 1'b1;
    cyc(4 * MS);
    general_input_i[2] = 1'b0;
    cyc(1);
    general_input_i[2] = 1'b1;
    cyc(5 * MS);
    chk1("on wait", general_output_o[1], 1'b0);
    cyc(3 * MS + 10);
    chk1("on done", general_output_o[1], 1'b1);
    general_input_i[1] = 1'b0;
    cyc(5 * MS);
    chk1("off wait", general_output_o[1], 1'b1);
    cyc(3 * MS + 10);
    chk1("off done", general_output_o[1], 1'b0);
    wr(4'h3, CMD_PIN_CFG, 32'h0010_0044);
    alarm_i[5] = 1'b1;
    cyc(5 * MS);
    chk1("alarm masked", general_output_o[3], 1'b0);
    alarm_i[4] = 1'b1;
    cyc(MS - 5);
    chk1("alarm wait", general_output_o[3], 1'b0);
    cyc(2 * MS + 10);
    chk1("alarm on", general_output_o[3], 1'b1);
    wr(4'h0, CMD_PIN_CFG, 32'h0);
    wr(4'h0, CMD_MODE, 32'h1);
    setpoint_active_i = 16'h0022;
    cyc(4);
    check("setpoint", 32'(trim_output_pin_en_o), 32'h20);
    setpoint_active_i = 16'h0000;
    wr(4'h0, CMD_MARGIN, 32'h0000_405A);
    wr(4'h0, CMD_OPER, 32'h2);
    cyc(10);
    check("wait good", 32'(trim_output_pin_en_o), 32'h0);
    all_good_i = 1'b1;
    cyc(25 * MS);
    check("open loop", 32'({trim_output_pin_en_o[0], trim_output_pin_level_o[0]}), 32'h15A);
    wr(4'h0, CMD_PIN_CFG, 32'h41);
    cyc(5);
    chk1("override", trim_output_pin_en_o[0], 1'b0);
    wr(4'h0, CMD_OPER, 32'h0);
    wr(4'h0, CMD_PIN_CFG, 32'h0);
    wr(4'h0, CMD_MARGIN, 32'h80);
    wr(4'h0, CMD_TGT_HI, 32'h6000);
    wr(4'h0, CMD_OPER, 32'h2);
    for (i = 0; i < 25 * MS && trim_output_pin_en_o[0] !== 1'b1; i++) begin
      cyc(1);
    end
    check("start level", 32'(trim_output_pin_level_o[0]), 32'h80);
    for (i = 0; i < 30 * MS && trim_output_pin_level_o[0] === 8'h80; i++) begin
      cyc(1);
    end
    check("first step", 32'(trim_output_pin_level_o[0]), 32'h7F);
    cyc(18 * MS);
    check("step spacing", 32'(trim_output_pin_level_o[0]), 32'h7F);
    wr(4'h0, CMD_OPER, 32'h0);
    wr(4'h0, CMD_MARGIN, 32'h8010);
    wr(4'h0, CMD_TGT_HI, 32'h0840);
    wr(4'h2, CMD_MARGIN, 32'h80FE);
    wr(4'h2, CMD_TGT_HI, 32'hFFFF);
    wr(4'h0, CMD_OPER, 32'h2);
    wr(4'h2, CMD_OPER, 32'h2);
    cyc(65 * MS);
    check("own outputs", 32'(trim_output_pin_en_o), 32'h5);
    chk1("status", status_margin_o, 1'b1);
    chk1("alert", alert_o, 1'b1);
    rd(4'h0, CMD_STATUS);
    check("fault flags", rd_q, 32'h5);
    wr(4'h0, CMD_OPER, 32'h6);
    cyc(10);
    wr(4'h0, CMD_OPER, 32'h0);
    cyc(3);
    chk1("hold start", fault_hold_o, 1'b1);
    cyc(95 * MS);
    chk1("hold on", fault_hold_o, 1'b1);
    cyc(8 * MS);
    chk1("hold end", fault_hold_o, 1'b0);
    wr(4'h0, CMD_FLT_CLR, 32'h1);
    rd(4'h0, CMD_STATUS);
    check("fault clear", rd_q, 32'h4);
    rd(4'h2, CMD_DAC_LVL);
    check("full scale", rd_q, 32'h1FF);
    complete_run();
  end
endmodule
bind smd_margin_ctrl smd_margin_ctrl_checker #(.MS_CYCLES(MS_CYCLES)) u_smd_margin_ctrl_checker (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .cmd_i(cmd_i), .rsp_o(rsp_o), .all_good_i(all_good_i),
  .trim_output_pin_level_o(trim_output_pin_level_o), .trim_output_pin_en_o(trim_output_pin_en_o),
  .general_output_o(general_output_o), .general_output_oe_o(general_output_oe_o),
  .status_margin_o(status_margin_o), .alert_o(alert_o), .fault_hold_o(fault_hold_o));
